// File: gpi_pkg.sv
package gpi_pkg;
	// ----------------------------------------
	// Port geometry
	// ----------------------------------------
	localparam int PORT_W = 8; // Lines per port
	localparam int SINK_W = 4; // Sixteen sink levels
	localparam int SMALL_HI_W = 4; // Lines of high-current port in twelve-line variant
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_LOW_DATA = 8'h00;
	localparam logic [7:0] ADDR_HIGH_DATA = 8'h01;
	localparam logic [7:0] ADDR_LOW_IRQ_EN = 8'h04;
	localparam logic [7:0] ADDR_HIGH_IRQ_EN = 8'h05;
	localparam logic [7:0] ADDR_LOW_PULLUP = 8'h08;
	localparam logic [7:0] ADDR_HIGH_PULLUP = 8'h09;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_DATA = 8'hff; // Released lines idle high
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [7:0] RST_POL = 8'h00; // Rising edge by default
	localparam logic [3:0] RST_SINK = 4'h0;
	// ----------------------------------------
	// Clock
	// ----------------------------------------
	localparam int CORE_CLK_MHZ = 12; // Doubled resonator rate
endpackage

// File: gpi_edge.sv
`timescale 1ns/10ps
// ----------------------------------------
// Synchroniser, edge detect, pending latch
// ----------------------------------------
module gpi_edge (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Pin and control
	input wire logic pin_i,
	input wire logic enable_i,
	input wire logic falling_i,
	input wire logic ack_i,
	// Request
	output logic pending_o
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
		logic pend;
		logic [2:0] fill; // Real samples taken since reset
	} gpi_edge_s;
	gpi_edge_s st, next_st;
	logic edge_hit;
	// Next state: of the sync chain only sync2 and last feed the detector, gated by fill
	always_comb begin
		next_st = st;
		next_st.sync1 = pin_i;
		next_st.sync2 = st.sync1;
		next_st.last = st.sync2;
		next_st.fill = {st.fill[1:0], 1'b1};
		edge_hit = falling_i ? (st.last & ~st.sync2) : (~st.last & st.sync2);
		// Chain not yet full after reset: a pin held high is no edge
		edge_hit = edge_hit & st.fill[2];
		// Set wins over acknowledge so a coincident edge is not lost
		if (enable_i && edge_hit) begin
			next_st.pend = 1'b1;
		end else if (ack_i) begin
			next_st.pend = 1'b0;
		end
	end
	// State register
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign pending_o = st.pend;
	// Enabled edge sets the request next cycle
	property p_edge_sets;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(enable_i && edge_hit) |=> pending_o;
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("edge did not set request");
	// Request holds without acknowledge
	property p_holds;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(pending_o && !ack_i) |=> pending_o;
	endproperty
	a_holds: assert property (p_holds) else $error("request dropped early");
	// A rise held high for three samples is flagged the cycle after
	property p_rise;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(enable_i && !falling_i && !pin_i ##1 pin_i [*3]
			##0 enable_i && !falling_i && !ack_i) |=> pending_o;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed");
endmodule

// File: gpi_ports.sv
`timescale 1ns/10ps
// Operation
// - Two eight-line bidirectional ports
// - Twelve-line variant keeps high bits 0-3
// - Per-line software pull-up enable
// - Per-line four-bit sink level
// - Per-line interrupt enable
// - Edge interrupt with selectable polarity
// - Wake pin open-drain, never drives high
// - Wake pin rising edge raises interrupt
// - Clocked by doubled 12 MHz core clock
// - Data registers at 0x00, 0x01
// - Interrupt enables write-only at 0x04, 0x05
// - Pull-up controls write-only at 0x08, 0x09
module gpi_ports import gpi_pkg::*; #(
	parameter int HI_LINES = gpi_pkg::PORT_W // 8 full, 4 reduced
) (
	// Clock and reset, 12 MHz core clock
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// I/O register access
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	// Configuration ports
	input wire logic [gpi_pkg::PORT_W-1:0] low_pol_i,
	input wire logic [gpi_pkg::PORT_W-1:0] high_pol_i,
	input wire logic [2*gpi_pkg::PORT_W*gpi_pkg::SINK_W-1:0] sink_level_i,
	input wire logic wake_pull_low_i,
	input wire logic [2*gpi_pkg::PORT_W:0] irq_ack_i,
	// Port pins
	input wire logic [gpi_pkg::PORT_W-1:0] low_current_port_i,
	output logic [gpi_pkg::PORT_W-1:0] low_current_port_o,
	output logic [gpi_pkg::PORT_W-1:0] low_current_port_oe_o,
	output logic [gpi_pkg::PORT_W-1:0] low_pullup_o,
	input wire logic [gpi_pkg::PORT_W-1:0] high_current_port_i,
	output logic [gpi_pkg::PORT_W-1:0] high_current_port_o,
	output logic [gpi_pkg::PORT_W-1:0] high_current_port_oe_o,
	output logic [gpi_pkg::PORT_W-1:0] high_pullup_o,
	output logic [2*gpi_pkg::PORT_W*gpi_pkg::SINK_W-1:0] sink_level_o,
	// Wake pin
	input wire logic wake_i,
	output logic wake_o,
	output logic wake_oe_o,
	// Interrupt requests: bits 0-7 low, 8-15 high, 16 wake
	output logic [2*gpi_pkg::PORT_W:0] irq_pending_o
);
	import gpi_pkg::*;
	localparam int NL = 2 * PORT_W;
	localparam int SW = NL * SINK_W;
	// Only the full and the twelve-line variants have a pin map
	if (HI_LINES != PORT_W && HI_LINES != SMALL_HI_W) begin : g_bad_lines
		$error("HI_LINES must be 8 or 4");
	end
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] low_data; // Pin drive latch, low-current
		logic [7:0] high_data; // Pin drive latch, high-current
		logic [7:0] low_ie;
		logic [7:0] high_ie;
		logic [7:0] low_pu;
		logic [7:0] high_pu;
		logic [SW-1:0] sink; // Registered sink levels
		logic wake_low; // Wake pin pulldown
		logic [7:0] rdata;
	} gpi_ports_s;
	gpi_ports_s st, next_st;
	logic [7:0] hi_mask; // Lines present on the high port
	logic [NL:0] pins; // Raw pin levels, wake on top
	logic [NL:0] ena;
	logic [NL:0] fall;
	assign hi_mask = (HI_LINES == PORT_W) ? 8'hff : 8'h0f;
	assign pins = {wake_i, high_current_port_i & hi_mask, low_current_port_i};
	assign ena = {1'b1, st.high_ie & hi_mask, st.low_ie};
	assign fall = {1'b0, high_pol_i, low_pol_i}; // Wake pin rising only
	// ----------------------------------------
	// Edge detectors, one per line
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g <= NL; g++) begin : g_line
			gpi_edge u_edge (
				.sys_clk_i(sys_clk_i),
				.arst_n_i(arst_n_i),
				.pin_i(pins[g]),
				.enable_i(ena[g]),
				.falling_i(fall[g]),
				.ack_i(irq_ack_i[g]),
				.pending_o(irq_pending_o[g])
			);
		end
	endgenerate
	// ----------------------------------------
	// Register writes and reads
	// ----------------------------------------
	// Write-only registers read as zero; reads return pin levels
	always_comb begin
		next_st = st;
		next_st.sink = sink_level_i;
		next_st.wake_low = wake_pull_low_i;
		if (io_wr_i) begin
			case (io_addr_i)
				ADDR_LOW_DATA: next_st.low_data = io_wdata_i;
				ADDR_HIGH_DATA: next_st.high_data = io_wdata_i & hi_mask;
				ADDR_LOW_IRQ_EN: next_st.low_ie = io_wdata_i;
				ADDR_HIGH_IRQ_EN: next_st.high_ie = io_wdata_i & hi_mask;
				ADDR_LOW_PULLUP: next_st.low_pu = io_wdata_i;
				ADDR_HIGH_PULLUP: next_st.high_pu = io_wdata_i & hi_mask;
				default: ;
			endcase
		end
		next_st.rdata = 8'h00;
		if (io_rd_i) begin
			case (io_addr_i)
				ADDR_LOW_DATA: next_st.rdata = low_current_port_i;
				ADDR_HIGH_DATA: next_st.rdata = high_current_port_i & hi_mask;
				default: next_st.rdata = 8'h00;
			endcase
		end
	end
	// State register on the core clock
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st.low_data <= RST_DATA;
			st.high_data <= RST_DATA;
			st.low_ie <= RST_IRQ_EN;
			st.high_ie <= RST_IRQ_EN;
			st.low_pu <= RST_PULLUP;
			st.high_pu <= RST_PULLUP;
			st.sink <= {NL{RST_SINK}};
			st.wake_low <= 1'b0;
			st.rdata <= 8'h00;
		end else begin
			st <= next_st;
		end
	end
	// ----------------------------------------
	// Pin drive: a 1 releases, a 0 sinks
	// ----------------------------------------
	// Lines are quasi-bidirectional, so oe follows a zero in the latch
	assign low_current_port_o = 8'h00;
	assign low_current_port_oe_o = ~st.low_data;
	assign high_current_port_o = 8'h00;
	assign high_current_port_oe_o = ~st.high_data & hi_mask;
	assign low_pullup_o = st.low_pu;
	assign high_pullup_o = st.high_pu & hi_mask;
	assign sink_level_o = st.sink;
	assign wake_o = 1'b0; // Never drives high
	assign wake_oe_o = st.wake_low;
	assign io_rdata_o = st.rdata;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Open drain: the wake pin is only ever sunk
	property p_wake_od;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		!(wake_oe_o && wake_o);
	endproperty
	a_wake_od: assert property (p_wake_od) else $error("wake pin driven high");
	// Low pull-ups follow the written byte
	property p_pu_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_wr_i && io_addr_i == ADDR_LOW_PULLUP) |=> (low_pullup_o == $past(io_wdata_i));
	endproperty
	a_pu_write: assert property (p_pu_write) else $error("pull-up write lost");
	// A zero written to the latch sinks the line
	property p_data_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_wr_i && io_addr_i == ADDR_LOW_DATA) |=> (low_current_port_oe_o == ~$past(io_wdata_i));
	endproperty
	a_data_write: assert property (p_data_write) else $error("data write lost");
	// Write-only low enables read back as zero
	property p_ie_read_zero;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_rd_i && io_addr_i == ADDR_LOW_IRQ_EN) |=> (io_rdata_o == 8'h00);
	endproperty
	a_ie_read_zero: assert property (p_ie_read_zero) else $error("write-only read nonzero");
	// Absent high lines never sink in the small variant
	property p_hi_absent;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(HI_LINES == SMALL_HI_W) |-> (high_current_port_oe_o[7:4] == 4'h0);
	endproperty
	a_hi_absent: assert property (p_hi_absent) else $error("absent line driven");
	// Sink levels pass through one register stage
	property p_sink;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		1'b1 |=> (sink_level_o == $past(sink_level_i));
	endproperty
	a_sink: assert property (p_sink) else $error("sink level not held");
	// High pull-ups follow the write, masked to present lines
	property p_hi_pu_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_wr_i && io_addr_i == ADDR_HIGH_PULLUP) |=>
			(high_pullup_o == ($past(io_wdata_i) & hi_mask));
	endproperty
	a_hi_pu_write: assert property (p_hi_pu_write) else $error("high pull-up write lost");
	// High latch zeros sink only lines that exist
	property p_hi_data_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_wr_i && io_addr_i == ADDR_HIGH_DATA) |=>
			(high_current_port_oe_o == (~$past(io_wdata_i) & hi_mask));
	endproperty
	a_hi_data_write: assert property (p_hi_data_write) else $error("high data write lost");
	// Low data read returns the pin levels of the strobe cycle
	property p_rd_low;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_rd_i && io_addr_i == ADDR_LOW_DATA) |=> (io_rdata_o == $past(low_current_port_i));
	endproperty
	a_rd_low: assert property (p_rd_low) else $error("low data read wrong");
	// High data read hides absent lines
	property p_rd_high;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(io_rd_i && io_addr_i == ADDR_HIGH_DATA) |=>
			(io_rdata_o == ($past(high_current_port_i) & hi_mask));
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("high data read wrong");
	// Read data stands only after a strobe, zero otherwise
	property p_rd_idle;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		!io_rd_i |=> (io_rdata_o == 8'h00);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
endmodule

// File: gpi_board.sv
`timescale 1ns/10ps
// ----------------------------------------
// Board model: switches, pull-ups, RC network
// ----------------------------------------
module gpi_board (
	// Clock for floating-line model
	input wire logic clk_i,
	// Device pin controls
	input wire logic [7:0] low_oe_i,
	input wire logic [7:0] high_oe_i,
	input wire logic [7:0] low_pull_i,
	input wire logic [7:0] high_pull_i,
	input wire logic wake_oe_i,
	// Bench commands: switch presses, RC charged
	input wire logic [7:0] press_low_i,
	input wire logic [7:0] press_high_i,
	input wire logic rc_high_i,
	// Resolved pin levels
	output logic [7:0] low_pin_o,
	output logic [7:0] high_pin_o,
	output logic wake_pin_o
);
	logic flt; // Undriven line wanders, never a stable guess
	// Toggle each cycle
	always @(posedge clk_i) begin
		flt <= ~flt;
	end
	initial flt = 1'b0;
	// Sink or switch wins, else pull-up, else floating
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			low_pin_o[i] = (low_oe_i[i] | press_low_i[i]) ? 1'b0 : (low_pull_i[i] ? 1'b1 : flt);
			high_pin_o[i] = (high_oe_i[i] | press_high_i[i]) ? 1'b0 : (high_pull_i[i] ? 1'b1 : flt);
		end
	end
	// Open drain: only pulled low, RC charges it high
	assign wake_pin_o = wake_oe_i ? 1'b0 : rc_high_i;
endmodule

// File: gpi_ports_test.sv
`timescale 1ns/10ps
module gpi_ports_test;
	import gpi_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic sys_clk_i = 0, arst_n_i = 0, io_wr_i = 0, io_rd_i = 0, wake_pull_low_i = 0, rc_high = 0;
	logic [7:0] io_addr_i = 0, io_wdata_i = 0, io_rdata_o, low_pol_i = 0, high_pol_i = 0;
	logic [7:0] lo_i, lo_o, lo_oe, lo_pu, hi_i, hi_o, hi_oe, hi_pu, press_low = 0, press_high = 0;
	logic [63:0] sink_level_i = 0, sink_level_o;
	logic [16:0] irq_ack_i = 0, irq_pending_o;
	logic wake_i, wake_o, wake_oe_o;
	int n_mismatch = 0, check_count = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	gpi_ports i_gpi_ports (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.low_pol_i(low_pol_i), .high_pol_i(high_pol_i), .sink_level_i(sink_level_i),
		.wake_pull_low_i(wake_pull_low_i), .irq_ack_i(irq_ack_i), .low_current_port_i(lo_i),
		.low_current_port_o(lo_o), .low_current_port_oe_o(lo_oe), .low_pullup_o(lo_pu),
		.high_current_port_i(hi_i), .high_current_port_o(hi_o), .high_current_port_oe_o(hi_oe),
		.high_pullup_o(hi_pu), .sink_level_o(sink_level_o), .wake_i(wake_i), .wake_o(wake_o),
		.wake_oe_o(wake_oe_o), .irq_pending_o(irq_pending_o));
	gpi_board i_gpi_board (.clk_i(sys_clk_i), .low_oe_i(lo_oe), .high_oe_i(hi_oe),
		.low_pull_i(lo_pu), .high_pull_i(hi_pu), .wake_oe_i(wake_oe_o), .press_low_i(press_low),
		.press_high_i(press_high), .rc_high_i(rc_high), .low_pin_o(lo_i), .high_pin_o(hi_i),
		.wake_pin_o(wake_i));
	// ----------------------------------------
	// Tasks: all entered just after an edge
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		io_wr_i = 1;
		io_addr_i = a;
		io_wdata_i = d;
		tick(1);
		io_wr_i = 0;
		// Strobe rests a cycle so back-to-back calls never reassign it in one step
		tick(1);
	endtask
	// Read data lands on the strobe edge and is sampled just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		io_rd_i = 1;
		io_addr_i = a;
		tick(1);
		io_rd_i = 0;
		d = io_rdata_o;
		tick(1);
	endtask
	// Bounded wait for a pending request
	task automatic wait_irq(input int idx);
		int k;
		for (k = 0; k < 12 && irq_pending_o[idx] !== 1'b1; k++) tick(1);
		if (k == 12) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		repeat (16) @(posedge sys_clk_i);
		#1 arst_n_i = 1;
		chk({lo_oe, hi_oe, irq_pending_o}, 0);
		wr(ADDR_LOW_PULLUP, 8'hff);
		wr(ADDR_HIGH_PULLUP, 8'h3c);
		tick(1);
		chk({lo_pu, hi_pu}, 16'hff3c);
		wr(ADDR_HIGH_PULLUP, 8'hff);
		wr(ADDR_LOW_DATA, 8'h5a);
		wr(ADDR_HIGH_DATA, 8'h0f);
		tick(1);
		chk({lo_oe, hi_oe, lo_o, hi_o}, 32'ha5f00000);
		rd(ADDR_LOW_DATA, d);
		chk(d, 8'h5a);
		rd(ADDR_HIGH_DATA, d);
		chk(d, 8'h0f);
		rd(ADDR_LOW_IRQ_EN, d);
		chk(d, 8'h00);
		rd(ADDR_HIGH_PULLUP, d);
		chk(d, 8'h00);
		wr(ADDR_LOW_DATA, 8'hff);
		wr(ADDR_HIGH_DATA, 8'hff);
		sink_level_i = 64'h0123456789abcdef;
		tick(2);
		chk(sink_level_o, 64'h0123456789abcdef);
		// Falling edge on enabled line 0, line 1 disabled
		low_pol_i = 8'h01;
		wr(ADDR_LOW_IRQ_EN, 8'h01);
		press_low = 8'h03;
		wait_irq(0);
		chk(irq_pending_o, 17'h00001);
		irq_ack_i = 17'h00001;
		tick(1);
		irq_ack_i = 0;
		press_low = 0;
		tick(6);
		chk(irq_pending_o, 0);
		// Rising edge on high line 7
		wr(ADDR_HIGH_IRQ_EN, 8'h80);
		press_high = 8'h80;
		tick(6);
		chk(irq_pending_o, 0);
		press_high = 0;
		tick(2);
		chk(irq_pending_o[15], 1'b0);
		wait_irq(15);
		chk(irq_pending_o, 17'h08000);
		// Wake pin: pulled low, then released onto RC
		wake_pull_low_i = 1;
		tick(1);
		rc_high = 1; // Pin already sunk, so no glitch reaches the detector
		tick(6);
		chk({wake_oe_o, wake_o, irq_pending_o[16]}, 3'b100);
		wake_pull_low_i = 0;
		wait_irq(16);
		chk(irq_pending_o[16], 1'b1);
		print_verdict();
	end
endmodule
